// ==== hdl/tx_fc_cfg_map.vh ====
// register map, field positions and reset values of the transmit flow control block
`ifndef TX_FC_CFG_MAP_VH
`define TX_FC_CFG_MAP_VH

// apb word indices; words 0..6 mirror vector bits 223:0, 32 bits per word
`define CFG_IDX_W         3
`define CFG_WORDS         7
`define STATUS_IDX        3'h7
`define STAGE_BITS        224

// writable bits of each vector word; all other bits read as zero
`define MASK_W0           32'hFFFF_4030
`define MASK_W1           32'hFFFF_FFFF
`define MASK_W2_PFC       32'hFF03_FFFF
`define MASK_W2_BASE      32'h0000_FFFF
`define MASK_PAIR         32'hFFFF_FFFF
`define MASK_NONE         32'h0000_0000

// vector field positions
`define B_JUMBO_EN        4
`define B_LEGACY_FC_EN    5
`define B_MAX_FRAME_EN    14
`define F_MAX_FRAME_LO    16
`define F_SRC_ADDR_LO     32
`define B_PFC_EN          80
`define B_AUTO_XON        81
`define F_PRIO_EN_LO      88
`define F_QUANTA_LO       96
`define F_PAIR_STRIDE     32
`define F_REFRESH_OFS     16
`define FIELD_W           16

// reset value of the staged vector: max frame size 1518, everything else off
`define STAGE_RESET       224'h05EE_0000

`define LEGAL_MAX_LEN     16'h05EE
`define NO_LIMIT16        16'hFFFF
`define ONE16             16'h0001
`define ZERO16            16'h0000

// status word bits
`define S_PFC_PEND        0
`define S_PAUSE_PEND      1
`define S_STAGE_PEND      2
`define S_ACTIVE_LO       8

`endif

// ==== hdl/tx_flow_control_config_vector.v ====
// transmit flow control configuration: apb staging, frame boundary apply, frame triggers
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/100ps
`include "tx_fc_cfg_map.vh"

//
// Operation
// RL1 - refresh frame when quanta count hits threshold
// RL2 - enabled asserted priority sends its quanta field
// RL3 - per-priority enable gates each request input
// RL4 - auto resume sends zero quanta on release
// RL5 - global enable switches priority flow control
// RL6 - user avoids global plus legacy enable together
// RL7 - source address matched and sent in frames
// RL8 - address bit zero first, low byte first
// RL9 - max size limits length when enabled, not jumbo
// RL10 - user programs max frame size 1518 or more
// RL11 - refresh field sits above its quanta field
// RL12 - changes apply only between frames
// RL13 - bits 80 upward exist only with pfc build
// RL14 - legacy enable lets pause request send frame
// RL15 - oversize frames pass below programmed maximum
// RL16 - reserved vector bits are ignored
module tx_flow_control_config_vector #(
  parameter PFC_PRESENT = 1,
  parameter NUM_PRIO    = 8,
  parameter NUM_QUANTA  = 4
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        tx_frame_busy,
  input  wire        quanta_tick,
  input  wire        priority_request_valid_0,
  input  wire        priority_request_valid_1,
  input  wire        priority_request_valid_2,
  input  wire        priority_request_valid_3,
  input  wire        priority_request_valid_4,
  input  wire        priority_request_valid_5,
  input  wire        priority_request_valid_6,
  input  wire        priority_request_valid_7,
  input  wire        pause_request,
  output reg         pfc_frame_req,
  input  wire        pfc_frame_ack,
  output reg  [7:0]  pfc_class_active,
  output reg  [15:0] pfc_quanta_0,
  output reg  [15:0] pfc_quanta_1,
  output reg  [15:0] pfc_quanta_2,
  output reg  [15:0] pfc_quanta_3,
  output reg         pause_frame_req,
  output reg         pause_is_xon,
  input  wire        pause_frame_ack,
  output reg  [47:0] pause_source_addr,
  input  wire [47:0] rx_dest_addr,
  input  wire        rx_dest_valid,
  output reg         rx_dest_match,
  output reg  [15:0] max_frame_limit,
  input  wire [15:0] tx_frame_len,
  input  wire        tx_len_valid,
  output reg         tx_len_ok
);

  // ----------------------------------------------------------------
  // apb staging registers
  // ----------------------------------------------------------------
  reg  [`STAGE_BITS-1:0] stage;
  reg  [`STAGE_BITS-1:0] live;
  reg                    stage_pend;
  wire [`CFG_IDX_W-1:0]  widx    = paddr[`CFG_IDX_W+1:2];
  wire                   mapped  = (paddr[11:`CFG_IDX_W+2] == 7'h00) && (paddr[1:0] == 2'b00);
  wire                   wr_hit  = psel && penable && pwrite && mapped && (widx != `STATUS_IDX);
  wire                   setup   = psel && !penable;

  // reserved bits and absent pfc words never store
  function [31:0] word_mask;
    input [`CFG_IDX_W-1:0] i;
    begin
      case (i)
        3'h0:    word_mask = `MASK_W0;
        3'h1:    word_mask = `MASK_W1;
        3'h2:    word_mask = (PFC_PRESENT != 0) ? `MASK_W2_PFC : `MASK_W2_BASE; // RL13
        3'h3,
        3'h4,
        3'h5,
        3'h6:    word_mask = (PFC_PRESENT != 0) ? `MASK_PAIR : `MASK_NONE; // RL13
        default: word_mask = `MASK_NONE;
      endcase
    end
  endfunction

  wire [31:0] stage_word = stage[widx*32 +: 32];
  wire [31:0] status_word;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage <= `STAGE_RESET;
    end else if (wr_hit) begin
      stage[widx*32 +: 32] <= pwdata & word_mask(widx); // RL16
    end
  end

  // read data is prepared in the setup cycle so pready can stay high
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready  <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (setup) begin
        pslverr <= !mapped;
        if (!mapped)
          prdata <= 32'h0000_0000;
        else if (widx == `STATUS_IDX)
          prdata <= status_word;
        else
          prdata <= stage_word & word_mask(widx); // RL16
      end
    end
  end

  // ----------------------------------------------------------------
  // frame boundary apply
  // ----------------------------------------------------------------
  // a write landing in the apply cycle keeps the pending flag set
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      live       <= `STAGE_RESET;
      stage_pend <= 1'b0;
    end else begin
      if (!tx_frame_busy) begin
        live <= stage; // RL12
      end
      if (wr_hit)
        stage_pend <= 1'b1;
      else if (!tx_frame_busy)
        stage_pend <= 1'b0; // RL12
    end
  end

  wire       pfc_on   = (PFC_PRESENT != 0) && live[`B_PFC_EN]; // RL5 RL13
  wire       auto_xon = (PFC_PRESENT != 0) && live[`B_AUTO_XON]; // RL4
  wire [7:0] prio_en  = live[`F_PRIO_EN_LO +: 8];
  wire [7:0] req_in   = {priority_request_valid_7, priority_request_valid_6,
                         priority_request_valid_5, priority_request_valid_4,
                         priority_request_valid_3, priority_request_valid_2,
                         priority_request_valid_1, priority_request_valid_0};

  // ----------------------------------------------------------------
  // per-priority trigger engines
  // ----------------------------------------------------------------
  wire [NUM_PRIO-1:0] act = req_in & prio_en & {NUM_PRIO{pfc_on}}; // RL3 RL5
  reg  [NUM_PRIO-1:0] act_q;
  reg  [NUM_PRIO-1:0] long_q;
  wire [NUM_PRIO-1:0] trig;
  wire [16*NUM_QUANTA-1:0] quanta_sel;

  genvar g;
  generate
    for (g = 0; g < NUM_PRIO; g = g + 1) begin : prio
      wire rise = act[g] && !act_q[g];
      wire fall = !act[g] && act_q[g] && long_q[g] && auto_xon; // RL4
      wire hit;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          act_q[g]  <= 1'b0;
          long_q[g] <= 1'b0;
        end else begin
          act_q[g]  <= act[g];
          long_q[g] <= act[g] && act_q[g];
        end
      end
      if (g < NUM_QUANTA) begin : cnt
        localparam QLO = `F_QUANTA_LO + g*`F_PAIR_STRIDE;
        wire [15:0] qval    = live[QLO +: `FIELD_W]; // RL11
        wire [15:0] refresh = live[QLO+`F_REFRESH_OFS +: `FIELD_W]; // RL11
        reg  [15:0] qcount;
        assign hit = act[g] && act_q[g] && (qcount == refresh); // RL1
        always @(posedge pclk or negedge presetn) begin
          if (!presetn)
            qcount <= `ZERO16;
          else if (!act[g] || rise || hit)
            qcount <= `ZERO16;
          else if (quanta_tick)
            qcount <= qcount + `ONE16; // RL1
        end
        assign quanta_sel[16*g +: 16] = act[g] ? qval : `ZERO16; // RL2 RL4
      end else begin : nocnt
        assign hit = 1'b0;
      end
      assign trig[g] = rise || fall || hit;
    end
  endgenerate

  // ----------------------------------------------------------------
  // frame requests towards the transmitter
  // ----------------------------------------------------------------
  // a new trigger in the ack cycle wins, so no event is lost
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pfc_frame_req    <= 1'b0;
      pfc_class_active <= 8'h00;
      pfc_quanta_0     <= `ZERO16;
      pfc_quanta_1     <= `ZERO16;
      pfc_quanta_2     <= `ZERO16;
      pfc_quanta_3     <= `ZERO16;
    end else begin
      if (|trig) begin
        pfc_frame_req    <= 1'b1; // RL1 RL4
        pfc_class_active <= act | (act_q & ~act); // RL3
        pfc_quanta_0     <= quanta_sel[15:0]; // RL2
        pfc_quanta_1     <= quanta_sel[31:16];
        pfc_quanta_2     <= quanta_sel[47:32];
        pfc_quanta_3     <= quanta_sel[63:48];
      end else if (pfc_frame_ack) begin
        pfc_frame_req <= 1'b0;
      end
    end
  end

  // legacy pause path; no automatic refresh since its refresh field is not held here
  wire lact = live[`B_LEGACY_FC_EN] && pause_request; // RL14
  reg  lact_q;
  reg  llong_q;
  wire lrise = lact && !lact_q;
  wire lfall = !lact && lact_q && llong_q && auto_xon; // RL4

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lact_q          <= 1'b0;
      llong_q         <= 1'b0;
      pause_frame_req <= 1'b0;
      pause_is_xon    <= 1'b0;
    end else begin
      lact_q  <= lact;
      llong_q <= lact && lact_q;
      if (lrise || lfall) begin
        pause_frame_req <= 1'b1; // RL14
        pause_is_xon    <= lfall; // RL4
      end else if (pause_frame_ack) begin
        pause_frame_req <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // address and frame length
  // ----------------------------------------------------------------
  wire [47:0] src_addr = live[`F_SRC_ADDR_LO +: 48];
  wire [15:0] max_size = live[`F_MAX_FRAME_LO +: `FIELD_W];
  wire        jumbo    = live[`B_JUMBO_EN];
  wire        max_en   = live[`B_MAX_FRAME_EN];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pause_source_addr <= 48'h0000_0000_0000;
      rx_dest_match     <= 1'b0;
      max_frame_limit   <= `LEGAL_MAX_LEN;
      tx_len_ok         <= 1'b0;
    end else begin
      // bit 0 is the group bit, bits 7:0 leave first on the line
      pause_source_addr <= src_addr; // RL7 RL8
      rx_dest_match     <= rx_dest_valid && (rx_dest_addr == src_addr); // RL7
      // jumbo lifts any limit, so the reported limit always agrees with tx_len_ok
      max_frame_limit   <= jumbo ? `NO_LIMIT16 : (max_en ? max_size : `LEGAL_MAX_LEN); // RL9
      if (tx_len_valid) begin
        if (jumbo)
          tx_len_ok <= 1'b1;
        else if (max_en)
          tx_len_ok <= (tx_frame_len <= max_size); // RL9 RL15
        else
          tx_len_ok <= (tx_frame_len <= `LEGAL_MAX_LEN);
      end
    end
  end

  assign status_word = {16'h0000, act_q, 5'h00, stage_pend, pause_frame_req, pfc_frame_req};

endmodule // tx_flow_control_config_vector

// ==== tb/tx_fc_cfg_properties.sv ====
// port checker of the transmit flow control block
`timescale 1ns/100ps
module tx_fc_cfg_properties (
  input logic        pclk,
  input logic        presetn,
  input logic        tx_frame_busy,
  input logic [47:0] pause_source_addr,
  input logic [15:0] max_frame_limit,
  input logic [15:0] tx_frame_len,
  input logic        tx_len_valid,
  input logic        tx_len_ok,
  input logic [47:0] rx_dest_addr,
  input logic        rx_dest_valid,
  input logic        rx_dest_match,
  input logic        pfc_frame_req,
  input logic        pfc_frame_ack,
  input logic [7:0]  pfc_class_active,
  input logic [15:0] pfc_quanta_0,
  input logic        pause_frame_req,
  input logic        pause_frame_ack
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----
  // properties
  // ----
  a_src_hold: assert property ($past(tx_frame_busy) |-> $stable(pause_source_addr))
    else $error("source address moved in frame");
  a_max_hold: assert property ($past(tx_frame_busy) |-> $stable(max_frame_limit))
    else $error("size limit moved in frame");
  a_len_check: assert property (tx_len_valid |=> tx_len_ok ==
    ($past(tx_frame_len) <= $past(max_frame_limit))) else $error("length verdict wrong");
  a_dest_match: assert property (rx_dest_valid |=> rx_dest_match ==
    ($past(rx_dest_addr) == $past(pause_source_addr))) else $error("match wrong");
  a_pfc_stand: assert property (pfc_frame_req && !pfc_frame_ack |=> pfc_frame_req)
    else $error("frame request dropped");
  a_pfc_class: assert property ($rose(pfc_frame_req) |-> pfc_class_active != 8'h00)
    else $error("frame with no class");
  a_idle_zero: assert property (pfc_frame_req && !pfc_class_active[0]
    |-> pfc_quanta_0 == 16'h0000) else $error("idle class quanta not zero");
  a_pause_stand: assert property (pause_frame_req && !pause_frame_ack
    |=> pause_frame_req) else $error("pause request dropped");
endmodule // tx_fc_cfg_properties

// ==== tb/tx_fc_ack_model.sv ====
// frame sender model that acknowledges frame requests
`timescale 1ns/100ps
module tx_fc_ack_model (
  input  logic pclk,
  input  logic presetn,
  input  logic slow,
  input  logic req,
  output logic ack
);
  logic [2:0] cnt;
  // ----
  // ack after one or six cycles; one pulse per request
  // ----
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 3'h0;
      ack <= 1'b0;
    end else if (ack) begin
      cnt <= 3'h0;
      ack <= 1'b0;
    end else if (req) begin
      cnt <= cnt + 3'h1;
      ack <= (cnt == (slow ? 3'h5 : 3'h0));
    end
  end
endmodule // tx_fc_ack_model

// ==== tb/tx_flow_control_config_vector_tb_top.sv ====
// self-checking bench of the transmit flow control block
`timescale 1ns/100ps
module tx_flow_control_config_vector_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, rerr, slow, quanta_tick;
  logic        tx_frame_busy, pause_request, rx_dest_valid, tx_len_valid;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd, seed, t, q, w1, w2;
  logic [7:0]  prv;
  logic [47:0] rx_dest_addr;
  logic [15:0] tx_frame_len, mx;
  integer      errors, samples_checked;
  wire  [31:0] prdata;
  wire         pready, pslverr, pfc_frame_req, pfc_frame_ack, pause_frame_req;
  wire         pause_frame_ack, pause_is_xon, rx_dest_match, tx_len_ok;
  wire  [7:0]  pfc_class_active;
  wire  [15:0] pfc_quanta_0, pfc_quanta_1, pfc_quanta_2, pfc_quanta_3, max_frame_limit;
  wire  [47:0] pause_source_addr;
  tx_flow_control_config_vector dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .tx_frame_busy, .quanta_tick, .pause_request,
    .pfc_frame_req, .pfc_frame_ack, .pfc_class_active, .pfc_quanta_0, .pfc_quanta_1,
    .pfc_quanta_2, .pfc_quanta_3, .pause_frame_req, .pause_is_xon, .pause_frame_ack,
    .pause_source_addr, .rx_dest_addr, .rx_dest_valid, .rx_dest_match, .max_frame_limit,
    .tx_frame_len, .tx_len_valid, .tx_len_ok,
    .priority_request_valid_0(prv[0]), .priority_request_valid_1(prv[1]),
    .priority_request_valid_2(prv[2]), .priority_request_valid_3(prv[3]),
    .priority_request_valid_4(prv[4]), .priority_request_valid_5(prv[5]),
    .priority_request_valid_6(prv[6]), .priority_request_valid_7(prv[7]));
  tx_fc_ack_model pfc_ack_u (.pclk, .presetn, .slow, .req(pfc_frame_req), .ack(pfc_frame_ack));
  tx_fc_ack_model psa_ack_u (.pclk, .presetn, .slow, .req(pause_frame_req),
    .ack(pause_frame_ack));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // ----
  // helpers
  // ----
  function [31:0] rnd;
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    rnd = seed;
  endfunction
  task close_out;
    $display("errors=%0d checks=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input bit c, input integer id);
    samples_checked++;
    if (!c) begin
      errors++;
      $display("CHECK FAILED t=%0t check %0d", $time, id);
    end
  endtask
  task apb(input bit w, input [11:0] a, input [31:0] d);
    integer n;
    @(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk) penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'b00;
    if (pready !== 1'b1) begin errors++; close_out; end
  endtask
  task wait_sig(input bit p, input bit v);
    integer n;
    n = 0;
    do begin @(posedge pclk); n++; end
    while ((p ? pause_frame_req : pfc_frame_req) !== v && n < 40);
    if ((p ? pause_frame_req : pfc_frame_req) !== v) begin errors++; close_out; end
  endtask
  task lenq(input [15:0] len, input bit exp, input integer id);
    @(posedge pclk) {tx_frame_len, tx_len_valid} <= {len, 1'b1};
    @(posedge pclk) tx_len_valid <= 1'b0;
    @(negedge pclk) chk(tx_len_ok === exp, id);
  endtask
  task tick;
    @(posedge pclk) quanta_tick <= 1'b1;
    @(posedge pclk) quanta_tick <= 1'b0;
  endtask
  // ----
  // scenarios
  // ----
  initial begin
    {seed, errors, samples_checked} = {32'h0000_8fad, 64'h0};
    {presetn, psel, penable, pwrite, paddr, pwdata, slow, quanta_tick, prv} = 0;
    {tx_frame_busy, pause_request, rx_dest_valid, rx_dest_addr, tx_len_valid} = 0;
    tx_frame_len = 16'h0000;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h000, 0); chk(rd === 32'h05EE_0000 && max_frame_limit === 16'h05EE, 1);
    apb(0, 12'h020, 0); chk(rerr === 1'b1, 2);
    apb(0, 12'h002, 0); chk(rerr === 1'b1, 3);
    w1 = rnd(); w2 = rnd(); q = rnd();
    w2[31:16] = 16'h01FF; q[31:16] = 16'h0003; q[0] = 1'b1;
    apb(1, 12'h004, w1); apb(1, 12'h008, w2); apb(1, 12'h00C, q);
    apb(0, 12'h008, 0); chk(rd === (w2 & 32'hFF03_FFFF), 4);
    apb(0, 12'h00C, 0); chk(rd === q, 5);
    repeat (3) @(posedge pclk);
    chk(pause_source_addr === {w2[15:0], w1}, 6);
    @(posedge pclk) {rx_dest_addr, rx_dest_valid} <= {w2[15:0], w1, 1'b1};
    @(posedge pclk) rx_dest_valid <= 1'b0;
    @(negedge pclk) chk(rx_dest_match === 1'b1, 7);
    @(posedge pclk) prv <= 8'h02;
    repeat (8) @(posedge pclk);
    chk(pfc_frame_req === 1'b0, 8);
    @(posedge pclk) prv <= 8'h01;
    wait_sig(0, 1);
    @(negedge pclk) chk(pfc_class_active === 8'h01 && pfc_quanta_0 === q[15:0] &&
      {pfc_quanta_1, pfc_quanta_2, pfc_quanta_3} === 48'h0000_0000_0000, 9);
    wait_sig(0, 0); tick; tick;
    repeat (4) @(posedge pclk);
    chk(pfc_frame_req === 1'b0, 10);
    tick; wait_sig(0, 1);
    @(negedge pclk) chk(pfc_quanta_0 === q[15:0], 11);
    wait_sig(0, 0);
    @(posedge pclk) {slow, prv} <= {1'b1, 8'h00};
    wait_sig(0, 1);
    @(negedge pclk) chk(pfc_class_active[0] === 1'b1 && pfc_quanta_0 === 16'h0000, 12);
    wait_sig(0, 0);
    apb(1, 12'h008, w2 & 32'hFFFE_FFFF);
    repeat (3) @(posedge pclk);
    prv <= 8'h01;
    repeat (8) @(posedge pclk);
    chk(pfc_frame_req === 1'b0, 13);
    t = rnd(); mx = 16'h05EE + {6'h00, t[9:0]};
    apb(1, 12'h000, {mx, 16'h4020});
    repeat (3) @(posedge pclk);
    chk(max_frame_limit === mx, 14);
    lenq(mx, 1'b1, 15);
    lenq(mx + 16'h0001, 1'b0, 16);
    @(posedge pclk) {prv, pause_request} <= 9'h001;
    wait_sig(1, 1); chk(pause_is_xon === 1'b0, 17);
    wait_sig(1, 0);
    @(posedge pclk) pause_request <= 1'b0;
    wait_sig(1, 1); chk(pause_is_xon === 1'b1, 18);
    wait_sig(1, 0);
    tx_frame_busy <= 1'b1;
    apb(1, 12'h000, {mx, 16'h4010});
    apb(0, 12'h01C, 0); chk(rd === 32'h0000_0004, 23);
    repeat (4) @(posedge pclk);
    chk(max_frame_limit === mx, 19);
    tx_frame_busy <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(max_frame_limit === 16'hFFFF, 20);
    pause_request <= 1'b1;
    repeat (8) @(posedge pclk);
    chk(pause_frame_req === 1'b0, 21);
    pause_request <= 1'b0;
    repeat (4) begin
      t = rnd();
      lenq({5'h01, t[10:0]}, 1'b1, 22);
    end
    apb(1, 12'h000, {mx, 16'h0000});
    repeat (3) @(posedge pclk);
    repeat (4) begin
      t = rnd();
      lenq({5'h00, t[10:0]}, {5'h00, t[10:0]} <= 16'h05EE, 24);
    end
    close_out;
  end
endmodule // tx_flow_control_config_vector_tb_top
bind tx_flow_control_config_vector tx_fc_cfg_properties chk_u (.pclk, .presetn,
  .tx_frame_busy, .pause_source_addr, .max_frame_limit, .tx_frame_len, .tx_len_valid,
  .tx_len_ok, .rx_dest_addr, .rx_dest_valid, .rx_dest_match, .pfc_frame_req,
  .pfc_frame_ack, .pfc_class_active, .pfc_quanta_0, .pause_frame_req, .pause_frame_ack);
